// [logic/bms_spi_map.svh]
`ifndef BMS_SPI_MAP_SVH
`define BMS_SPI_MAP_SVH

// frame lengths in serial clock bits
`define BMS_BITS_PLAIN 5'd16
`define BMS_BITS_CRC 5'd24
`define BMS_BIT_MSB 5'd23
`define BMS_BIT_SAT 5'd31
`define BMS_BIT_ONE 5'd1

// checksum
`define BMS_CRC_POLY 8'h07
`define BMS_CRC_INIT 8'h00

// flag patterns
`define BMS_PAT_ONES16 16'hffff
`define BMS_CRC_ERR 8'haa
`define BMS_CRC_NOTUPD 8'h00
`define BMS_CRC_ONES 8'hff

// guarded address and data
`define BMS_GUARD_ADDR 7'h7f
`define BMS_GUARD_DATA 8'hff

// timing, in the unit named
`define BMS_CLK_NS 10
`define BMS_INPUT_GLITCH_FILTER_EN_NS 200
`define BMS_WAKE_US 50
`define BMS_SEC_NS 1000000000
`define BMS_FROZEN_S 2
`define BMS_IDLE_MIN_S 8'h01

`endif

// [logic/bms_spi_pkg.sv]
package bms_spi_pkg;

    // one request or response word, first byte then second byte
    typedef struct packed {
        logic       rw;
        logic [6:0] addr;
        logic [7:0] data;
    } bms_word_s;

    typedef enum logic [1:0] {
        OSC_OFF  = 2'b00,
        OSC_WAKE = 2'b01,
        OSC_RUN  = 2'b10,
        OSC_HOLD = 2'b11
    } bms_osc_e;

endpackage

// [logic/bms_spi_target.sv]
`timescale 1ns/100ps
`include "bms_spi_map.svh"
// Contract
// R1 - mode zero: sample rising, drive falling
// R2 - frames are 16 bits, or 24 with checksum
// R3 - checksum is crc8, poly x8+x2+x+1
// R4 - without checksum, wrong bit count is error
// R5 - with checksum, accept only valid checksum frames
// R6 - checksum mismatch: discard, return ffff then aa
// R7 - oscillator off at start: return all ones
// R8 - select fall wakes oscillator, 50 us start
// R9 - no valid frame writes ff to 7f
// R10 - oscillator held idle time, at least 1 s
// R11 - host leaves 50 us between frames
// R12 - select low, clock static 2 s: reset link
// R13 - supply select applies only after switch command; code also loads it from the configuration right after reset
// R14 - 200 ns input filter, bypass when disabled
// R15 - first byte: direction bit, 7-bit address, msb first
// R16 - second byte write data, ignored for reads
// R17 - host sends checksum of first two bytes third
// R18 - buffer not refreshed: return ffff then 00
// R19 - consumed write echoed via outgoing buffer
// R20 - read answer loaded, checksum over it returned
// R21 - late buffer loads return not-updated pattern
// R22 - interface change only by reset or switch command
// R23 - host retries after each flag pattern
// R24 - checksum starts at zero, msb first
// R25 - all bytes shifted msb first
module bms_spi_target
    import bms_spi_pkg::*;
#(
    parameter int WAKE_CYCLES = (`BMS_WAKE_US * 1000) / `BMS_CLK_NS,
    parameter int SEC_CYCLES = `BMS_SEC_NS / `BMS_CLK_NS,
    parameter int FROZEN_CYCLES = `BMS_FROZEN_S * (`BMS_SEC_NS / `BMS_CLK_NS)
) (
    // clocks and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_spi_sclk,
    // serial pins
    input wire logic i_spi_cs_b,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // configuration
    input wire logic i_crc_en,
    input wire logic i_input_glitch_filter_en,
    input wire logic [7:0] i_comm_idle_time,
    input wire logic i_out_pin_supply_select_cfg,
    input wire logic i_iface_spi_cfg,
    input wire logic i_switch_to_four_wire_cmd,
    input wire logic i_swap_iface_cmd,
    // internal logic side
    output logic o_req_valid,
    output bms_word_s o_req,
    input wire logic i_rsp_valid,
    input wire bms_word_s i_rsp,
    // status
    output logic o_fast_internal_oscillator_en,
    output logic o_osc_ready,
    output logic o_frame_err,
    output logic o_crc_err,
    output logic o_bus_frozen,
    output logic o_out_pin_supply_select,
    output logic o_spi_active
);

    localparam int INPUT_GLITCH_FILTER_EN_CYCLES = (`BMS_INPUT_GLITCH_FILTER_EN_NS + `BMS_CLK_NS - 1) / `BMS_CLK_NS;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        logic fb;
        c = `BMS_CRC_INIT; // [R24]
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ `BMS_CRC_POLY; // [R3]
            end
        end
        return c;
    endfunction

    function automatic logic tx_bit(input logic [23:0] w, input logic [4:0] n);
        logic [4:0] idx;
        idx = `BMS_BIT_MSB - n;
        if (n > `BMS_BIT_MSB) begin
            return 1'b0;
        end
        return w[idx];
    endfunction

    // ---------------- link domain ----------------
    logic link_rst_q;
    logic [23:0] tx_q;
    logic [4:0] cnt_q;
    logic [4:0] last_cnt_q;
    logic [23:0] rx_q;
    logic tog_q;
    logic miso_q;
    wire logic frame_rst_b = i_rst_b & ~i_spi_cs_b & ~link_rst_q;
    wire logic link_rst_b = i_rst_b & ~link_rst_q;

    // bit count restarts with every frame, so it is reset by select itself
    always_ff @(posedge i_spi_sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != `BMS_BIT_SAT) begin
            cnt_q <= cnt_q + `BMS_BIT_ONE;
        end
    end

    // captured data must outlive the frame for the core side to read it
    always_ff @(posedge i_spi_sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            rx_q <= 24'h000000;
            last_cnt_q <= 5'h00;
            tog_q <= 1'b0;
        end else begin
            rx_q <= {rx_q[22:0], i_spi_mosi}; // [R1] [R15] [R25]
            last_cnt_q <= (cnt_q == `BMS_BIT_SAT) ? cnt_q : cnt_q + `BMS_BIT_ONE;
            tog_q <= ~tog_q;
        end
    end

    always_ff @(negedge i_spi_sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_bit(tx_q, cnt_q); // [R1] [R25]
        end
    end

    // first bit must stand before any clock edge, so it comes from the frozen word
    assign o_spi_miso = (cnt_q == 5'h00) ? tx_q[23] : miso_q;

    // ---------------- core domain ----------------
    logic cs_s1_q, cs_s2_q, cs_f_q, cs_d_q;
    logic [4:0] input_glitch_filter_en_cnt_q;
    logic tog_s1_q, tog_s2_q, tog_d_q;
    logic seen_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_d_q <= 1'b0;
        end else begin
            cs_s1_q <= i_spi_cs_b;
            cs_s2_q <= cs_s1_q;
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_d_q <= tog_s2_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_f_q <= 1'b1;
            cs_d_q <= 1'b1;
            input_glitch_filter_en_cnt_q <= 5'h00;
        end else begin
            cs_d_q <= cs_f_q;
            if (!i_input_glitch_filter_en || cs_s2_q == cs_f_q) begin // [R14]
                cs_f_q <= cs_s2_q;
                input_glitch_filter_en_cnt_q <= 5'h00;
            end else if (input_glitch_filter_en_cnt_q == 5'(INPUT_GLITCH_FILTER_EN_CYCLES - 1)) begin
                cs_f_q <= cs_s2_q; // [R14]
                input_glitch_filter_en_cnt_q <= 5'h00;
            end else begin
                input_glitch_filter_en_cnt_q <= input_glitch_filter_en_cnt_q + 5'h01;
            end
        end
    end

    wire logic cs_fall = cs_d_q & ~cs_f_q;
    wire logic cs_rise = ~cs_d_q & cs_f_q;
    wire logic sclk_edge = tog_s2_q ^ tog_d_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seen_q <= 1'b0;
        end else if (sclk_edge) begin
            seen_q <= 1'b1;
        end else if (cs_fall) begin
            seen_q <= 1'b0;
        end
    end

    // oscillator wake and idle hysteresis
    bms_osc_e osc_q;
    logic [31:0] osc_cnt_q;
    logic [7:0] sec_q;
    wire logic [7:0] idle_s = (i_comm_idle_time == 8'h00) ? `BMS_IDLE_MIN_S : i_comm_idle_time;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_q <= OSC_OFF;
            osc_cnt_q <= 32'h00000000;
            sec_q <= 8'h00;
        end else begin
            case (osc_q)
                OSC_OFF: begin
                    osc_cnt_q <= 32'h00000000;
                    if (cs_fall) begin
                        osc_q <= OSC_WAKE; // [R8]
                    end
                end
                OSC_WAKE: begin
                    if (osc_cnt_q == 32'(WAKE_CYCLES - 1)) begin
                        osc_q <= OSC_RUN; // [R8]
                        osc_cnt_q <= 32'h00000000;
                    end else begin
                        osc_cnt_q <= osc_cnt_q + 32'h00000001;
                    end
                end
                OSC_RUN: begin
                    osc_cnt_q <= 32'h00000000;
                    sec_q <= idle_s; // [R10]
                    if (cs_f_q) begin
                        osc_q <= OSC_HOLD;
                    end
                end
                OSC_HOLD: begin
                    if (!cs_f_q) begin
                        osc_q <= OSC_RUN;
                    end else if (osc_cnt_q == 32'(SEC_CYCLES - 1)) begin
                        osc_cnt_q <= 32'h00000000;
                        sec_q <= sec_q - 8'h01;
                        if (sec_q == 8'h01) begin
                            osc_q <= OSC_OFF; // [R10]
                        end
                    end else begin
                        osc_cnt_q <= osc_cnt_q + 32'h00000001;
                    end
                end
                default: begin
                    osc_q <= OSC_OFF;
                end
            endcase
        end
    end

    wire logic osc_ready = (osc_q == OSC_RUN) || (osc_q == OSC_HOLD);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fast_internal_oscillator_en <= 1'b0;
            o_osc_ready <= 1'b0;
        end else begin
            o_fast_internal_oscillator_en <= (osc_q != OSC_OFF);
            o_osc_ready <= osc_ready;
        end
    end

    // frozen bus: select low and no clock edge for the timeout
    logic [31:0] frz_cnt_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frz_cnt_q <= 32'h00000000;
            link_rst_q <= 1'b0;
            o_bus_frozen <= 1'b0;
        end else begin
            link_rst_q <= 1'b0;
            o_bus_frozen <= 1'b0;
            if (cs_f_q || sclk_edge) begin
                frz_cnt_q <= 32'h00000000;
            end else if (frz_cnt_q == 32'(FROZEN_CYCLES - 1)) begin
                frz_cnt_q <= 32'h00000000;
                link_rst_q <= 1'b1; // [R12]
                o_bus_frozen <= 1'b1;
            end else begin
                frz_cnt_q <= frz_cnt_q + 32'h00000001;
            end
        end
    end

    // end of frame: link registers are static once select is high
    wire logic [4:0] nbits = seen_q ? last_cnt_q : 5'h00;
    wire logic len_ok = nbits == (i_crc_en ? `BMS_BITS_CRC : `BMS_BITS_PLAIN); // [R2]
    wire logic [15:0] rx_word = i_crc_en ? rx_q[23:8] : rx_q[15:0];
    wire logic crc_ok = !i_crc_en || (crc8(rx_word) == rx_q[7:0]); // [R5] [R17]
    wire bms_word_s rx_s = rx_word;
    wire logic guard = rx_s.rw && rx_s.addr == `BMS_GUARD_ADDR && rx_s.data == `BMS_GUARD_DATA;
    wire logic frame_end = cs_rise && o_spi_active;
    wire logic bad_crc = frame_end && len_ok && !crc_ok;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req_valid <= 1'b0;
            o_req <= '0;
            o_frame_err <= 1'b0;
            o_crc_err <= 1'b0;
        end else begin
            o_req_valid <= frame_end && len_ok && crc_ok && !guard; // [R9] [R5]
            o_frame_err <= frame_end && !len_ok; // [R4]
            o_crc_err <= bad_crc; // [R6]
            if (frame_end) begin
                o_req <= rx_s; // [R15] [R16]
            end
        end
    end

    // outgoing buffer, refreshed by internal logic
    bms_word_s out_q;
    logic updated_q;
    logic crc_err_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_q <= '0;
            updated_q <= 1'b0;
            crc_err_q <= 1'b0;
        end else begin
            if (i_rsp_valid) begin
                out_q <= i_rsp; // [R19] [R20]
            end
            // a refresh in the frame-end cycle wins over the consume
            if (i_rsp_valid) begin
                updated_q <= 1'b1;
            end else if (frame_end) begin
                updated_q <= 1'b0; // [R18] [R21]
            end
            if (bad_crc) begin
                crc_err_q <= 1'b1; // [R6]
            end else if (frame_end || i_rsp_valid) begin
                crc_err_q <= 1'b0;
            end
        end
    end

    // word frozen while select is low; the host must allow the sync delay
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_q <= {`BMS_PAT_ONES16, `BMS_CRC_ONES};
        end else if (cs_f_q) begin
            if (!osc_ready) begin
                tx_q <= {`BMS_PAT_ONES16, `BMS_CRC_ONES}; // [R7]
            end else if (crc_err_q) begin
                tx_q <= {`BMS_PAT_ONES16, `BMS_CRC_ERR}; // [R6]
            end else if (!updated_q) begin
                tx_q <= {`BMS_PAT_ONES16, `BMS_CRC_NOTUPD}; // [R18]
            end else begin
                tx_q <= {out_q, crc8(out_q)}; // [R20]
            end
        end
    end

    // interface selection and pin supply
    logic boot_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_q <= 1'b1;
            o_spi_active <= 1'b0;
            o_out_pin_supply_select <= 1'b0;
            o_spi_miso_oe <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                o_spi_active <= i_iface_spi_cfg; // [R22]
                o_out_pin_supply_select <= i_out_pin_supply_select_cfg;
            end else if (i_switch_to_four_wire_cmd) begin
                o_spi_active <= 1'b1; // [R22]
                o_out_pin_supply_select <= i_out_pin_supply_select_cfg; // [R13]
            end else if (i_swap_iface_cmd) begin
                o_spi_active <= i_iface_spi_cfg;
                o_out_pin_supply_select <= i_out_pin_supply_select_cfg; // [R13]
            end
            o_spi_miso_oe <= !cs_f_q && o_spi_active;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    chk_wake_on_fall: assert property (cs_fall && osc_q == OSC_OFF |=> osc_q == OSC_WAKE) // [R8]
        else $error("select fall did not wake oscillator");
    chk_wake_delay: assert property ($rose(osc_ready) |-> $past(osc_q) == OSC_WAKE
        && $past(osc_cnt_q) == 32'(WAKE_CYCLES - 1)) // [R8]
        else $error("oscillator ready before start time");
    chk_notready_word: assert property (cs_f_q && !osc_ready
        |=> tx_q == {`BMS_PAT_ONES16, `BMS_CRC_ONES}) // [R7]
        else $error("not-ready pattern missing");
    chk_crc_err_word: assert property (o_crc_err && osc_ready && cs_f_q && !i_rsp_valid
        |=> tx_q == {`BMS_PAT_ONES16, `BMS_CRC_ERR}) // [R6]
        else $error("checksum error pattern missing");
    chk_req_length: assert property (o_req_valid |-> $past(len_ok) && $past(crc_ok)) // [R5]
        else $error("request passed with bad length or checksum");
    chk_frame_error: assert property (frame_end && !len_ok |=> o_frame_err && !o_req_valid) // [R4]
        else $error("wrong bit count not flagged");
    chk_guard_word: assert property (o_req_valid |-> !(o_req.rw
        && o_req.addr == `BMS_GUARD_ADDR && o_req.data == `BMS_GUARD_DATA)) // [R9]
        else $error("guarded write forwarded");
    chk_not_updated: assert property (frame_end && !i_rsp_valid |=> !updated_q) // [R18]
        else $error("buffer still marked fresh after frame");
    chk_frozen_reset: assert property (o_bus_frozen |-> link_rst_q
        && $past(cs_f_q) == 1'b0) // [R12]
        else $error("frozen reset without select low");
    chk_supply_change: assert property (!boot_q && !$past(boot_q)
        && $changed(o_out_pin_supply_select)
        |-> $past(i_switch_to_four_wire_cmd) || $past(i_swap_iface_cmd)) // [R13]
        else $error("supply select changed without command");
    chk_tx_frozen: assert property (!cs_f_q |=> $stable(tx_q)) // [R1]
        else $error("outgoing word changed during frame");

endmodule

// [testbench/bms_host_model.sv]
`timescale 1ns/100ps
module bms_host_model (
    // serial pins
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_mosi,
    input wire logic i_miso
);
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end

    // tx and rx are left aligned at bit 23; the clock only runs inside a frame
    task automatic xfer(input int nbits, input logic [23:0] tx, output logic [23:0] rx);
        rx = '0;
        o_cs_b = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            o_mosi = tx[23 - i];
            #62.5;
            o_sclk = 1'b1;
            rx[23 - i] = i_miso;
            #62.5;
            o_sclk = 1'b0;
        end
        #62.5;
        o_cs_b = 1'b1;
        // a released line must not keep showing the last bit
        o_mosi = ~o_mosi;
    endtask

    task automatic set_cs(input logic v);
        o_cs_b = v;
    endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import bms_spi_pkg::*;
    typedef struct {
        logic crc;
        int nb;
        logic [23:0] tx;
        logic ld;
        logic [15:0] rsp;
        logic [23:0] exp;
        int dreq;
        int dfe;
        int dce;
    } bms_row_s;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic sclk, cs_b, mosi, miso, miso_oe;
    logic crc_en = 1'b0;
    logic input_glitch_filter_en_en = 1'b0;
    logic [7:0] idle = 8'h04;
    logic sup_cfg = 1'b0;
    logic spi_cfg = 1'b1;
    logic sw_cmd = 1'b0;
    logic swap_cmd = 1'b0;
    logic rsp_valid = 1'b0;
    bms_word_s rsp = '0;
    bms_word_s req;
    logic req_valid, osc_en, osc_rdy, frame_err, crc_err, frozen, sup_sel, active;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int n_req = 0, n_fe = 0, n_ce = 0, n_fz = 0;
    bms_row_s rows [10];
    logic [23:0] rx;
    int lat, b_req, b_fe, b_ce, cw;

    bms_spi_target #(.WAKE_CYCLES(20), .SEC_CYCLES(50), .FROZEN_CYCLES(300)) dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_spi_sclk(sclk), .i_spi_cs_b(cs_b),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_crc_en(crc_en),
        .i_input_glitch_filter_en(input_glitch_filter_en_en), .i_comm_idle_time(idle),
        .i_out_pin_supply_select_cfg(sup_cfg), .i_iface_spi_cfg(spi_cfg),
        .i_switch_to_four_wire_cmd(sw_cmd), .i_swap_iface_cmd(swap_cmd),
        .o_req_valid(req_valid), .o_req(req), .i_rsp_valid(rsp_valid), .i_rsp(rsp),
        .o_fast_internal_oscillator_en(osc_en), .o_osc_ready(osc_rdy),
        .o_frame_err(frame_err), .o_crc_err(crc_err), .o_bus_frozen(frozen),
        .o_out_pin_supply_select(sup_sel), .o_spi_active(active));
    bms_host_model host (.o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso));

    always #5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (req_valid === 1'b1) n_req <= n_req + 1;
        if (frame_err === 1'b1) n_fe <= n_fe + 1;
        if (crc_err === 1'b1) n_ce <= n_ce + 1;
        if (frozen === 1'b1) n_fz <= n_fz + 1;
        if (cycles > 15000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    // checksum worked out independently, msb first
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ (((c[7] ^ w[i]) == 1'b1) ? 8'h07 : 8'h00);
        return c;
    endfunction

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp, input string what);
        compares++;
        if (got != exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic load(input logic [15:0] w);
        rsp = w;
        rsp_valid = 1'b1;
        wt(1);
        rsp_valid = 1'b0;
    endtask

    task automatic cmd(input logic sw);
        if (sw) sw_cmd = 1'b1;
        else swap_cmd = 1'b1;
        wt(1);
        sw_cmd = 1'b0;
        swap_cmd = 1'b0;
        wt(3);
    endtask

    // lat counts cycles from select rise to the request pulse, 40 if none
    task automatic frame(input logic c, input int nb, input logic [23:0] tx);
        crc_en = c;
        host.xfer(nb, tx, rx);
        lat = 0;
        while (req_valid !== 1'b1 && lat < 40) begin
            @(negedge i_core_clk);
            lat++;
        end
        wt(40);
    endtask

    task automatic end_sim;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        rows[0] = '{1'b0, 16, 24'h815500, 1'b1, 16'h0a33, 24'h0a3300, 1, 0, 0};
        rows[1] = '{1'b0, 16, 24'h051200, 1'b0, 16'h0, 24'hffff00, 1, 0, 0};
        rows[2] = '{1'b0, 15, 24'h815500, 1'b0, 16'h0, 24'hffff00, 0, 1, 0};
        rows[3] = '{1'b0, 17, 24'h815500, 1'b0, 16'h0, 24'hffff00, 0, 1, 0};
        rows[4] = '{1'b1, 24, {16'h8155, crc8(16'h8155)}, 1'b1, 16'h0a33,
                    {16'h0a33, crc8(16'h0a33)}, 1, 0, 0};
        rows[5] = '{1'b1, 24, {16'h0512, ~crc8(16'h0512)}, 1'b1, 16'h1234,
                    {16'h1234, crc8(16'h1234)}, 0, 0, 1};
        rows[6] = '{1'b1, 24, {16'h0512, crc8(16'h0512)}, 1'b0, 16'h0, 24'hffffaa, 1, 0, 0};
        rows[7] = '{1'b1, 16, 24'h051200, 1'b0, 16'h0, 24'hffff00, 0, 1, 0};
        rows[8] = '{1'b1, 24, {16'hffff, crc8(16'hffff)}, 1'b0, 16'h0, 24'hffff00, 0, 0, 0};
        rows[9] = '{1'b0, 16, 24'hffff00, 1'b1, 16'h9abc, 24'h9abc00, 0, 0, 0};
        wt(10);
        check_word(osc_en, 0, "osc in reset");
        i_rst_b = 1'b1;
        wt(3);
        check_word(active, 1, "active after reset");
        frame(1'b0, 16, 24'h815500);
        check_word(rx[23:8], 16'hffff, "cold frame");
        check_word({osc_en, osc_rdy}, 2'b11, "osc woken");
        foreach (rows[i]) begin
            b_req = n_req;
            b_fe = n_fe;
            b_ce = n_ce;
            if (rows[i].ld) load(rows[i].rsp);
            frame(rows[i].crc, rows[i].nb, rows[i].tx);
            cw = (rows[i].nb == 17) ? 16 : rows[i].nb;
            check_word(rx >> (24 - cw), rows[i].exp >> (24 - cw), "row rx");
            check_count(n_req - b_req, rows[i].dreq, "row req");
            check_count(n_fe - b_fe, rows[i].dfe, "row frame err");
            check_count(n_ce - b_ce, rows[i].dce, "row crc err");
            if (rows[i].dreq == 1) check_word(req, rows[i].tx[23:8], "row word");
        end
        wt(80);
        check_word(osc_en, 1, "osc held");
        wt(80);
        check_word(osc_en, 0, "osc idle off");
        frame(1'b1, 24, {16'h0512, crc8(16'h0512)});
        check_word(rx, 24'hffffff, "osc off crc");
        load(16'h0599);
        frame(1'b1, 24, {16'h0512, crc8(16'h0512)});
        check_word(rx, {16'h0599, crc8(16'h0599)}, "retry after not ready");
        input_glitch_filter_en_en = 1'b1;
        frame(1'b0, 16, 24'h051200);
        check_count(int'(lat >= 20 && lat < 40), 1, "filter delay");
        input_glitch_filter_en_en = 1'b0;
        frame(1'b0, 16, 24'h051200);
        check_count(int'(lat <= 8), 1, "filter bypass");
        idle = 8'h00;
        wt(250);
        host.xfer(16, 24'h051200, rx);
        wt(30);
        check_word(osc_en, 1, "zero idle held");
        wt(40);
        check_word(osc_en, 0, "zero idle off");
        host.set_cs(1'b0);
        wt(250);
        check_word({miso_oe, 8'(n_fz)}, 9'h100, "frozen early");
        wt(80);
        check_count(n_fz, 1, "frozen reset");
        host.set_cs(1'b1);
        wt(40);
        check_word(miso_oe, 0, "released");
        sup_cfg = 1'b1;
        wt(5);
        check_word(sup_sel, 0, "supply pending");
        cmd(1'b1);
        check_word(sup_sel, 1, "supply applied");
        spi_cfg = 1'b0;
        wt(5);
        check_word(active, 1, "iface pending");
        cmd(1'b0);
        check_word(active, 0, "iface swapped");
        b_req = n_req;
        frame(1'b0, 16, 24'h815500);
        check_count(n_req - b_req, 0, "inactive frame");
        cmd(1'b1);
        check_word(active, 1, "switch cmd");
        i_rst_b = 1'b0;
        wt(3);
        check_word({osc_en, active}, 2'b00, "second reset");
        i_rst_b = 1'b1;
        wt(3);
        check_word({active, sup_sel}, 2'b01, "reset reload");
        end_sim();
    end
endmodule
